// ---- dv/pfci_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Pin checker
// ---------------
module pfci_ctrl_chk (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire pfci_pkg::pfci_pins_t pins_o
);
    import pfci_pkg::*;
    logic [14:0] last_a_reg, last_a_next;
    logic [7:0] last_d_reg, last_d_next;
    always_comb begin
        last_a_next = last_a_reg;
        last_d_next = last_d_reg;
        if (!pins_o.we_n) begin
            last_a_next = pins_o.addr[14:0];
            last_d_next = pins_o.dq;
        end
    end
    always_ff @(posedge mclk_i) begin
        last_a_reg <= srst_i ? 15'h0000 : last_a_next;
        last_d_reg <= srst_i ? 8'h00 : last_d_next;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    chk_read_clean: assert property (!pins_o.oe_n |->
        !pins_o.dq_oe && !pins_o.ce_n && pins_o.we_n) else $error("bad read");
    chk_write_qual: assert property (!pins_o.we_n |->
        !pins_o.ce_n && pins_o.oe_n && pins_o.dq_oe) else $error("bad write");
    chk_we_width: assert property ($fell(pins_o.we_n) |=>
        pins_o.we_n && !pins_o.ce_n) else $error("strobe width");
    chk_data_hold: assert property ($rose(pins_o.we_n) |->
        $stable(pins_o.dq) && $stable(pins_o.addr) && pins_o.dq_oe)
        else $error("data not held");
    chk_read_len: assert property ($fell(pins_o.oe_n) |=>
        !pins_o.oe_n ##1 pins_o.oe_n) else $error("read length");
    chk_unlock_pair: assert property ($fell(pins_o.we_n) &&
        pins_o.addr[14:0] == 15'h2AA && pins_o.dq == 8'h55 |->
        last_d_reg == 8'hAA && last_a_reg == 15'h555) else $error("unlock");
    chk_unlock_code: assert property ($fell(pins_o.we_n) &&
        last_d_reg == 8'h55 && last_a_reg == 15'h2AA |-> pins_o.dq inside
        {8'hA0, 8'h80, 8'h90, 8'hF0, 8'h20, 8'h10}) else $error("code");
    chk_poll_after: assert property ($fell(pins_o.we_n) &&
        last_d_reg == 8'hA0 && last_a_reg == 15'h555 |->
        ##[2:8] $fell(pins_o.oe_n)) else $error("no poll");
    chk_reset_pins: assert property (disable iff (1'b0) srst_i |=>
        pins_o.ce_n && pins_o.we_n && !pins_o.dq_oe) else $error("reset");
    cover property ($fell(pins_o.we_n) && pins_o.dq == 8'hA0);
    cover property ($fell(pins_o.we_n) && pins_o.dq == 8'h90);
    cover property ($fell(pins_o.we_n) && pins_o.dq == 8'h20);
endmodule : pfci_ctrl_chk
bind pfci_ctrl pfci_ctrl_chk u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .pins_o(pins_o));
`default_nettype wire

// ---- dv/pfci_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pfci_regs.svh"
// ---------------
// Testbench
// ---------------
module pfci_ctrl_tb;
    import pfci_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] PART = 8'h3C; // Arbitrary value
    logic mclk_i, srst_i, cpu_wr_i, cpu_rd_i;
    logic [7:0] cpu_addr_i, dq_i, busy_len;
    logic [31:0] cpu_wdata_i, cpu_rdata_o, got;
    pfci_pins_t pins_o;
    int err_count, n_compared;
    int cyc = 0;
    pfci_ctrl #(.POLL_MAX(20)) dut (.mclk_i(mclk_i), .srst_i(srst_i),
        .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
        .cpu_rdata_o(cpu_rdata_o), .pins_o(pins_o), .dq_i(dq_i));
    pfci_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
        .pins_i(pins_o), .busy_len_i(busy_len), .dq_o(dq_i));
    always #20 mclk_i = ~mclk_i;
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        cpu_wr_i <= 1'b1;
        @(posedge mclk_i);
        cpu_wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        cpu_addr_i <= a;
        cpu_rd_i <= 1'b1;
        @(posedge mclk_i);
        cpu_rd_i <= 1'b0;
        #1 got = cpu_rdata_o;
        if (e !== 32'hFFFF_FFFF) check(got, e);
        @(posedge mclk_i);
    endtask : rd
    task automatic start(input pfci_op_t op, input logic [18:0] a,
            input logic [7:0] d);
        wr(`PFCI_ADR_ADDR, {13'h0000, a});
        wr(`PFCI_ADR_DATA, {24'h000000, d});
        wr(`PFCI_ADR_CMD, {29'h00000000, op});
    endtask : start
    task automatic done(input logic [31:0] stat, input logic [31:0] rdat);
        for (int i = 0; i < 3000; i++) begin
            rd(`PFCI_ADR_STAT, 32'hFFFF_FFFF);
            if (got[1:0] === 2'b01) break;
        end
        check(got, stat);
        if (rdat !== 32'hFFFF_FFFF) rd(`PFCI_ADR_RDAT, rdat);
    endtask : done
    task automatic byte_at(input logic [18:0] a, input logic [7:0] e);
        start(PFCI_OP_READ, a, 8'h00);
        done(32'h1, {24'h000000, e});
    endtask : byte_at
    initial begin
        {mclk_i, srst_i, cpu_wr_i, cpu_rd_i, cpu_addr_i, cpu_wdata_i} = '0;
        {err_count, n_compared} = '0;
        srst_i = 1'b1;
        busy_len = 8'h03;
        repeat (16) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        rd(`PFCI_ADR_STAT, 32'h1);
        rd(8'h14, 32'h0);
        byte_at(19'h00012, 8'hFF);
        $display("Test reset and map done");
        start(PFCI_OP_PROG, 19'h7FF12, 8'h5C);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00012, 8'h5C);
        start(PFCI_OP_PROG, 19'h00095, 8'h33);
        done(32'h1, 32'hFFFF_FFFF);
        $display("Test program done");
        start(PFCI_OP_IDIN, 19'h00000, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00000, MAKER);
        byte_at(19'h00001, PART);
        start(PFCI_OP_IDEX, 19'h00000, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00012, 8'h5C);
        start(PFCI_OP_IDIN, 19'h00000, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        start(PFCI_OP_IDEX3, 19'h00000, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00001, 8'hFF);
        $display("Test identification done");
        start(PFCI_OP_SECT, 19'h00012, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00012, 8'hFF);
        byte_at(19'h00095, 8'h33);
        start(PFCI_OP_CHIP, 19'h00000, 8'h00);
        done(32'h1, 32'hFFFF_FFFF);
        byte_at(19'h00095, 8'hFF);
        $display("Test erase done");
        start(PFCI_OP_PROG, 19'h00020, 8'h11);
        wr(`PFCI_ADR_ADDR, 32'h77);
        wr(`PFCI_ADR_CMD, 32'h6);
        done(32'h1, 32'hFFFF_FFFF);
        rd(`PFCI_ADR_ADDR, 32'h20);
        rd(`PFCI_ADR_DATA, 32'h11);
        byte_at(19'h00020, 8'h11);
        busy_len = 8'h28;
        start(PFCI_OP_PROG, 19'h00030, 8'h01);
        done(32'h5, 32'hFFFF_FFFF);
        wr(`PFCI_ADR_CMD, 32'h7);
        rd(`PFCI_ADR_STAT, 32'h1);
        $display("Test refusal and timeout done");
        stop_test();
    end
endmodule : pfci_ctrl_tb
`default_nettype wire

// ---- dv/pfci_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Flash device
// ---------------
module pfci_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h3C // Arbitrary value
) (
    input wire pfci_pkg::pfci_pins_t pins_i,
    input wire logic [7:0] busy_len_i,
    output logic [7:0] dq_o
);
    import pfci_pkg::*;
    logic [7:0] mem [0:255];
    logic [14:0] la;
    logic [7:0] ld, left, pd;
    logic tgl, idm, prg;
    int step;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {left, pd, tgl, idm, prg, dq_o} = '0;
        step = 0;
    end
    always @(negedge pins_i.we_n) la = pins_i.addr[14:0];
    always @(posedge pins_i.we_n) begin
        if (!pins_i.ce_n && pins_i.oe_n && left == 0) begin
            ld = pins_i.dq;
            if (step == 0 && ld == 8'hF0) idm = 0;
            case (step)
                0, 4: step = (la == 15'h555 && ld == 8'hAA) ? step + 1 : 0;
                1, 5: step = (la == 15'h2AA && ld == 8'h55) ? step + 1 : 0;
                2: begin
                    if (la == 15'h555 && ld inside {8'h90, 8'hF0})
                        idm = !ld[6];
                    step = (la != 15'h555) ? 0 : (ld == 8'hA0) ? 3
                         : (ld == 8'h80) ? 4 : 0;
                end
                3: begin
                    mem[la[7:0]] &= ld;
                    pd = ld;
                    prg = 1;
                    left = busy_len_i;
                    step = 0;
                end
                6: begin
                    foreach (mem[i])
                        if ((ld == 8'h20 && i[7] == la[7]) ||
                            (ld == 8'h10 && la == 15'h555))
                            mem[i] = 8'hFF;
                    prg = 0;
                    left = ld inside {8'h20, 8'h10} ? busy_len_i : 8'h00;
                    step = 0;
                end
                default: step = 0;
            endcase
        end
    end
    always @(negedge pins_i.oe_n) begin
        if (!pins_i.ce_n && pins_i.we_n) begin
            if (left != 0) begin
                tgl = !tgl;
                dq_o = {prg ? !pd[7] : 1'b0, tgl, 6'h00};
                left = left - 1;
            end else if (idm) begin
                if (pins_i.addr[14:0] == 15'h0000) dq_o = MAKER_ID;
                else if (pins_i.addr[14:0] == 15'h0001) dq_o = PART_ID;
                else dq_o = 8'h00;
            end else dq_o = mem[pins_i.addr[7:0]];
        end
    end
    always @(posedge pins_i.oe_n or posedge pins_i.ce_n) dq_o = ~dq_o;
endmodule : pfci_flash_model
`default_nettype wire

// ---- rtl/pfci_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pfci_regs.svh"
module pfci_ctrl #(
    parameter int POLL_MAX = 4000000
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [7:0] cpu_addr_i,
    input wire logic [31:0] cpu_wdata_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    output logic [31:0] cpu_rdata_o,
    output pfci_pkg::pfci_pins_t pins_o,
    input wire logic [7:0] dq_i
);
    import pfci_pkg::*;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Strobe widths far exceed the glitch floor of the device
    localparam int WL_CYC =
        (`PFCI_WR_LOW_NS + `PFCI_CLK_NS - 1) / `PFCI_CLK_NS;
    localparam int WH_CYC =
        (`PFCI_WR_HIGH_NS + `PFCI_CLK_NS - 1) / `PFCI_CLK_NS;
    localparam int RD_CYC =
        (`PFCI_RD_NS + `PFCI_CLK_NS - 1) / `PFCI_CLK_NS;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WLOW = 3'b001,
        S_WHIGH = 3'b010,
        S_RLOW = 3'b011,
        S_RGAP = 3'b100
    } pfci_st_t;

    function automatic logic [26:0] step(input pfci_op_t op,
            input logic [2:0] i, input logic [18:0] a, input logic [7:0] d);
        logic [18:0] ad;
        logic [7:0] dt;
        ad = (i[0] == 1'b0) ? `PFCI_UNL1_ADDR : `PFCI_UNL2_ADDR;
        dt = (i[0] == 1'b0) ? `PFCI_UNL1_DATA : `PFCI_UNL2_DATA;
        unique case (op)
            PFCI_OP_PROG: begin
                // Unlock writes, program code, then target byte
                if (i == 3'h2) begin
                    ad = `PFCI_UNL1_ADDR;
                    dt = `PFCI_PROG_DATA;
                end
                if (i == 3'h3) begin
                    ad = a;
                    dt = d;
                end
            end
            PFCI_OP_SECT, PFCI_OP_CHIP: begin
                // Six-write erase sequence
                if (i == 3'h2) begin
                    ad = `PFCI_UNL1_ADDR;
                    dt = `PFCI_ERASE_DATA;
                end
                if (i == 3'h3) begin
                    ad = `PFCI_UNL1_ADDR;
                    dt = `PFCI_UNL1_DATA;
                end
                if (i == 3'h4) begin
                    ad = `PFCI_UNL2_ADDR;
                    dt = `PFCI_UNL2_DATA;
                end
                if (i == 3'h5) begin
                    ad = (op == PFCI_OP_SECT) ? a : `PFCI_UNL1_ADDR;
                    dt = (op == PFCI_OP_SECT) ? `PFCI_SECT_DATA
                                              : `PFCI_CHIP_DATA;
                end
            end
            PFCI_OP_IDIN, PFCI_OP_IDEX3: begin
                // Unlock then entry or exit code
                if (i == 3'h2) begin
                    ad = `PFCI_UNL1_ADDR;
                    dt = (op == PFCI_OP_IDIN) ? `PFCI_IDIN_DATA
                                              : `PFCI_IDEX_DATA;
                end
            end
            PFCI_OP_IDEX: begin
                ad = a;
                dt = `PFCI_IDEX_DATA;
            end
            default: begin
                ad = a;
                dt = d;
            end
        endcase
        return {ad, dt};
    endfunction : step

    function automatic logic [2:0] nwrites(input pfci_op_t op);
        unique case (op)
            PFCI_OP_PROG: return 3'h4;
            PFCI_OP_SECT, PFCI_OP_CHIP: return 3'h6;
            PFCI_OP_IDIN, PFCI_OP_IDEX3: return 3'h3;
            PFCI_OP_IDEX: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction : nwrites

    pfci_st_t st_reg, st_next;
    pfci_op_t op_reg, op_next;
    logic [2:0] idx_reg, idx_next;
    logic [3:0] tmr_reg, tmr_next;
    logic [18:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] rdat_reg, rdat_next;
    logic [7:0] prev_reg, prev_next;
    logic first_reg, first_next;
    logic busy_reg, busy_next;
    logic tout_reg, tout_next;
    logic [31:0] pcnt_reg, pcnt_next;
    logic [31:0] cpu_rdata_reg, cpu_rdata_next;
    pfci_pins_t pins_reg, pins_next;
    logic [26:0] stp;

    assign stp = step(op_reg, idx_reg, addr_reg, data_reg);
    assign cpu_rdata_o = cpu_rdata_reg;
    assign pins_o = pins_reg;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        idx_next = idx_reg;
        tmr_next = tmr_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        rdat_next = rdat_reg;
        prev_next = prev_reg;
        first_next = first_reg;
        busy_next = busy_reg;
        tout_next = tout_reg;
        pcnt_next = pcnt_reg;
        pins_next = pins_reg;
        cpu_rdata_next = 32'h0;
        if (cpu_rd_i) begin
            unique case (cpu_addr_i)
                `PFCI_ADR_ADDR: cpu_rdata_next = {13'h0, addr_reg};
                `PFCI_ADR_DATA: cpu_rdata_next = {24'h0, data_reg};
                `PFCI_ADR_STAT: cpu_rdata_next = {29'h0, tout_reg,
                                                  busy_reg, st_reg == S_IDLE};
                `PFCI_ADR_RDAT: cpu_rdata_next = {24'h0, rdat_reg};
                default: cpu_rdata_next = 32'h0;
            endcase
        end
        if (cpu_wr_i && st_reg == S_IDLE && !busy_reg) begin
            // Only lines 14..0 matter for commands; upper held valid
            if (cpu_addr_i == `PFCI_ADR_ADDR) begin
                addr_next = cpu_wdata_i[18:0];
            end
            if (cpu_addr_i == `PFCI_ADR_DATA) begin
                data_next = cpu_wdata_i[7:0];
            end
        end
        unique case (st_reg)
            S_IDLE: begin
                pins_next.ce_n = 1'b1;
                pins_next.oe_n = 1'b1;
                pins_next.we_n = 1'b1;
                pins_next.dq_oe = 1'b0;
                // New command only after completion poll
                if (cpu_wr_i && cpu_addr_i == `PFCI_ADR_CMD && !busy_reg) begin
                    op_next = pfci_op_t'(cpu_wdata_i[2:0]);
                    idx_next = 3'h0;
                    tout_next = 1'b0;
                    if (op_next == PFCI_OP_READ) begin
                        st_next = S_RLOW;
                        tmr_next = 4'(RD_CYC);
                        pins_next.addr = addr_reg;
                        pins_next.ce_n = 1'b0;
                        pins_next.oe_n = 1'b0;
                    end else if (op_next != PFCI_OP_POLL) begin
                        st_next = S_WHIGH;
                        tmr_next = 4'(WH_CYC);
                    end
                end
            end
            S_WHIGH: begin
                if (tmr_reg > 4'h1) begin
                    tmr_next = tmr_reg - 4'h1;
                end else begin
                    // Gate high and select low while strobing
                    st_next = S_WLOW;
                    tmr_next = 4'(WL_CYC);
                    pins_next.addr = stp[26:8];
                    pins_next.dq = stp[7:0];
                    pins_next.dq_oe = 1'b1;
                    pins_next.oe_n = 1'b1;
                    pins_next.ce_n = 1'b0;
                    pins_next.we_n = 1'b0;
                end
            end
            S_WLOW: begin
                if (tmr_reg > 4'h1) begin
                    tmr_next = tmr_reg - 4'h1;
                end else begin
                    // Rising strobe latches data; bus released after the last write only
                    // Address and data set with the fall, both held over rise
                    pins_next.we_n = 1'b1;
                    idx_next = idx_reg + 3'h1;
                    if (idx_next == nwrites(op_reg)) begin
                        st_next = S_RGAP;
                        tmr_next = 4'(WH_CYC);
                        busy_next = (op_reg == PFCI_OP_PROG) ||
                                    (op_reg == PFCI_OP_SECT) ||
                                    (op_reg == PFCI_OP_CHIP);
                        first_next = 1'b1;
                        pcnt_next = 32'h0;
                    end else begin
                        st_next = S_WHIGH;
                        tmr_next = 4'(WH_CYC);
                    end
                end
            end
            S_RLOW: begin
                // Bus floated, gate and select low for read
                pins_next.dq_oe = 1'b0;
                if (tmr_reg > 4'h1) begin
                    tmr_next = tmr_reg - 4'h1;
                end else begin
                    pins_next.ce_n = 1'b1;
                    pins_next.oe_n = 1'b1;
                    rdat_next = dq_i;
                    prev_next = dq_i;
                    st_next = S_RGAP;
                    tmr_next = 4'(WH_CYC);
                    if (busy_reg) begin
                        // Done once toggle bit stops
                        if (!first_reg && dq_i[`PFCI_TOGGLE_BIT] ==
                                prev_reg[`PFCI_TOGGLE_BIT]) begin
                            busy_next = 1'b0;
                        end
                        first_next = 1'b0;
                        pcnt_next = pcnt_reg + 32'h1;
                        if (pcnt_reg == 32'(POLL_MAX)) begin
                            busy_next = 1'b0;
                            tout_next = 1'b1;
                        end
                    end
                end
            end
            S_RGAP: begin
                pins_next.ce_n = 1'b1;
                pins_next.dq_oe = 1'b0;
                if (tmr_reg > 4'h1) begin
                    tmr_next = tmr_reg - 4'h1;
                end else if (busy_reg) begin
                    // Polling starts after last strobe rise
                    st_next = S_RLOW;
                    tmr_next = 4'(RD_CYC);
                    pins_next.ce_n = 1'b0;
                    pins_next.oe_n = 1'b0;
                end else begin
                    st_next = S_IDLE;
                end
            end
            default: st_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_reg <= S_IDLE;
            op_reg <= PFCI_OP_READ;
            idx_reg <= 3'h0;
            tmr_reg <= 4'h0;
            addr_reg <= 19'h0;
            data_reg <= 8'h0;
            rdat_reg <= 8'h0;
            prev_reg <= 8'h0;
            first_reg <= 1'b0;
            busy_reg <= 1'b0;
            tout_reg <= 1'b0;
            pcnt_reg <= 32'h0;
            cpu_rdata_reg <= 32'h0;
            pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                          addr: 19'h0, dq: 8'h0, dq_oe: 1'b0};
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            idx_reg <= idx_next;
            tmr_reg <= tmr_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            rdat_reg <= rdat_next;
            prev_reg <= prev_next;
            first_reg <= first_next;
            busy_reg <= busy_next;
            tout_reg <= tout_next;
            pcnt_reg <= pcnt_next;
            cpu_rdata_reg <= cpu_rdata_next;
            pins_reg <= pins_next;
        end
    end
endmodule : pfci_ctrl
`default_nettype wire

// ---- rtl/pfci_pkg.sv ----
package pfci_pkg;
    typedef enum logic [2:0] {
        PFCI_OP_PROG = 3'h0,
        PFCI_OP_SECT = 3'h1,
        PFCI_OP_CHIP = 3'h2,
        PFCI_OP_IDIN = 3'h3,
        PFCI_OP_IDEX = 3'h4,
        PFCI_OP_IDEX3 = 3'h5,
        PFCI_OP_READ = 3'h6,
        PFCI_OP_POLL = 3'h7
    } pfci_op_t;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [18:0] addr;
        logic [7:0] dq;
        logic dq_oe;
    } pfci_pins_t;
endpackage : pfci_pkg

// ---- rtl/pfci_regs.svh ----
`ifndef PFCI_REGS_SVH
`define PFCI_REGS_SVH
`define PFCI_ADR_CMD 8'h00
`define PFCI_ADR_ADDR 8'h04
`define PFCI_ADR_DATA 8'h08
`define PFCI_ADR_STAT 8'h0C
`define PFCI_ADR_RDAT 8'h10
`define PFCI_UNL1_ADDR 19'h00555
`define PFCI_UNL2_ADDR 19'h002AA
`define PFCI_UNL1_DATA 8'hAA
`define PFCI_UNL2_DATA 8'h55
`define PFCI_PROG_DATA 8'hA0
`define PFCI_ERASE_DATA 8'h80
`define PFCI_SECT_DATA 8'h20
`define PFCI_CHIP_DATA 8'h10
`define PFCI_IDIN_DATA 8'h90
`define PFCI_IDEX_DATA 8'hF0
`define PFCI_TOGGLE_BIT 6
`define PFCI_WR_LOW_NS 40
`define PFCI_WR_HIGH_NS 40
`define PFCI_RD_NS 80
`define PFCI_CLK_NS 40
`endif
